// ==== scf_consts.vh ====
// constants for the flash trigger configuration and fault flag bank
`ifndef SCF_CONSTS_VH
`define SCF_CONSTS_VH

// register offsets on the serial control bus
`define SCF_ADDR_CONTROL      8'h06
`define SCF_ADDR_TRIG_CFG     8'h07
`define SCF_ADDR_FAULT        8'h08

// control register fields
`define SCF_CTRL_MODE_LO      0
`define SCF_CTRL_MODE_HI      1
`define SCF_CTRL_RSVD_BIT     2
`define SCF_CTRL_OUT_ON_BIT   3
`define SCF_MODE_RST          2'h0
`define SCF_OUT_ON_RST        1'h0

// operating mode codes
`define SCF_MODE_EXT_TORCH    2'h0
`define SCF_MODE_INDICATOR    2'h1
`define SCF_MODE_ASSIST       2'h2
`define SCF_MODE_FLASH        2'h3

// flash trigger configuration fields
`define SCF_TRIG_LEVEL_BIT    6
`define SCF_TRIG_EN_BIT       7
`define SCF_TRIG_LEVEL_RST    1'h1
`define SCF_TRIG_EN_RST       1'h1

// fault register fields
`define SCF_FLT_UVLO_BIT      0
`define SCF_FLT_RSVD1_BIT     1
`define SCF_FLT_RSVD2_BIT     2
`define SCF_FLT_TXMASK_BIT    3
`define SCF_FLT_TIMEOUT_BIT   4
`define SCF_FLT_RST           1'h0

// read data value for unmapped offsets and reserved bits
`define SCF_RDATA_RST         8'h00

`endif

// ==== scf_sticky_flag.v ====
// one sticky fault flag, set by hardware, cleared by a host read
`timescale 1ns/1ps
`default_nettype none
`include "scf_consts.vh"

module scf_sticky_flag (
    input  wire core_clk,
    input  wire nrst,
    input  wire set_cond,
    input  wire rd_clr,
    output reg  flag_q
);

    reg flag_d;

    // set wins over clear: a fault still present survives the read
    always @* begin
        flag_d = flag_q;
        if (set_cond) begin
            flag_d = 1'b1;
        end else if (rd_clr) begin
            flag_d = 1'b0;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flag_q <= `SCF_FLT_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule // scf_sticky_flag

`default_nettype wire

// ==== scf_regs.v ====
// flash trigger configuration, control and fault flag register bank
//
// Summary of operation
// [RULE1] assist mode drops the current's top bit, halving the maximum.
// [RULE2] trigger config bit 6 picks edge (0) or level (1) sensing; resets 1.
// [RULE3] trigger config bit 7 enables the trigger in flash mode; resets 1.
// [RULE4] fault bit 0 sets on undervoltage during a flash; resets 0.
// [RULE5] fault bit 3 sets when the mask/torch input is high during flash.
// [RULE6] fault bit 4 sets when a flash pulse hits the timeout limit.
// [RULE7] fault bits 1 and 2 are reserved, read only, read zero.
// [RULE8] mode 11 is flash; after each pulse mode and sink enable clear; a control write in the same cycle wins over the clear.
// [RULE9] fault flags hold until read; read clears unless fault persists.
`timescale 1ns/1ps
`default_nettype none
`include "scf_consts.vh"

module scf_regs #(
    parameter CUR_W = 8
) (
    input  wire             core_clk,
    input  wire             nrst,
    // register access from the serial control bus
    input  wire [7:0]       reg_addr,
    input  wire [7:0]       reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [7:0]       reg_rdata_q,
    // current setting and its effective value
    input  wire [CUR_W-1:0] led_current_in,
    output reg  [CUR_W-1:0] eff_current_q,
    // flash sequencing and fault sources
    input  wire             flash_active,
    input  wire             flash_done,
    input  wire             uvlo_evt,
    input  wire             txmask_in,
    input  wire             timeout_evt,
    // flash trigger pin
    input  wire             trig_in,
    // control, configuration, trigger and fault flag outputs
    output reg  [1:0]       mode_q,
    output reg              out_on_q,
    output reg              trig_level_q,
    output reg              trig_en_q,
    output reg              flash_trig_q,
    output reg  [7:0]       fault_q
);

    reg  [1:0]       mode_d;
    reg              out_on_d;
    reg              trig_level_d;
    reg              trig_en_d;
    reg              flash_trig_d;
    reg              trig_prev_q;
    reg  [7:0]       reg_rdata_d;
    reg  [CUR_W-1:0] eff_current_d;
    reg  [7:0]       fault_d;

    wire             wr_ctrl;
    wire             wr_trig;
    wire             rd_fault;
    wire             uvlo_flag;
    wire             txmask_flag;
    wire             timeout_flag;
    wire             set_uvlo;
    wire             set_txmask;
    wire             set_timeout;
    wire             in_flash_mode;

    assign wr_ctrl       = reg_wr && (reg_addr == `SCF_ADDR_CONTROL);
    assign wr_trig       = reg_wr && (reg_addr == `SCF_ADDR_TRIG_CFG);
    assign rd_fault      = reg_rd && (reg_addr == `SCF_ADDR_FAULT);
    assign in_flash_mode = (mode_q == `SCF_MODE_FLASH);

    // control register

    always @* begin
        mode_d   = mode_q;
        out_on_d = out_on_q;
        // host write wins: a new flash command is never swallowed
        if (wr_ctrl) begin
            mode_d   = reg_wdata[`SCF_CTRL_MODE_HI:`SCF_CTRL_MODE_LO];
            out_on_d = reg_wdata[`SCF_CTRL_OUT_ON_BIT];
        end else if (flash_done && in_flash_mode) begin
            // [RULE8] auto clear after pulse
            mode_d   = `SCF_MODE_EXT_TORCH;
            out_on_d = 1'b0;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_q   <= `SCF_MODE_RST;
            out_on_q <= `SCF_OUT_ON_RST;
        end else begin
            mode_q   <= mode_d;
            out_on_q <= out_on_d;
        end
    end

    // trigger configuration

    always @* begin
        trig_level_d = trig_level_q;
        trig_en_d    = trig_en_q;
        if (wr_trig) begin
            // [RULE2] sensing type bit
            trig_level_d = reg_wdata[`SCF_TRIG_LEVEL_BIT];
            // [RULE3] trigger enable bit
            trig_en_d    = reg_wdata[`SCF_TRIG_EN_BIT];
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trig_level_q <= `SCF_TRIG_LEVEL_RST;
            trig_en_q    <= `SCF_TRIG_EN_RST;
        end else begin
            trig_level_q <= trig_level_d;
            trig_en_q    <= trig_en_d;
        end
    end

    // trigger qualification

    // level mode follows the pin; edge mode gives one cycle per rise
    always @* begin
        flash_trig_d = 1'b0;
        // [RULE3] gate by enable and mode
        if (trig_en_q && in_flash_mode) begin
            // [RULE2] edge or level sensing
            if (trig_level_q) begin
                flash_trig_d = trig_in;
            end else begin
                flash_trig_d = trig_in && !trig_prev_q;
            end
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trig_prev_q  <= 1'b0;
            flash_trig_q <= 1'b0;
        end else begin
            trig_prev_q  <= trig_in;
            flash_trig_q <= flash_trig_d;
        end
    end

    // effective current

    always @* begin
        eff_current_d = led_current_in;
        // [RULE1] assist drops top bit
        if (mode_q == `SCF_MODE_ASSIST) begin
            eff_current_d = {1'b0, led_current_in[CUR_W-2:0]};
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            eff_current_q <= {CUR_W{1'b0}};
        end else begin
            eff_current_q <= eff_current_d;
        end
    end

    // fault flags

    // [RULE4] undervoltage during flash
    assign set_uvlo    = uvlo_evt && flash_active;
    // [RULE5] mask input during flash
    assign set_txmask  = txmask_in && flash_active;
    // [RULE6] timeout limit reached
    assign set_timeout = timeout_evt;

    // [RULE9] sticky until read
    scf_sticky_flag u_flag_uvlo (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set_cond (set_uvlo),
        .rd_clr   (rd_fault),
        .flag_q   (uvlo_flag)
    );

    scf_sticky_flag u_flag_txmask (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set_cond (set_txmask),
        .rd_clr   (rd_fault),
        .flag_q   (txmask_flag)
    );

    scf_sticky_flag u_flag_timeout (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set_cond (set_timeout),
        .rd_clr   (rd_fault),
        .flag_q   (timeout_flag)
    );

    // upper fault bits belong to other monitors and read zero here
    always @* begin
        fault_d = 8'h00;
        fault_d[`SCF_FLT_UVLO_BIT]    = uvlo_flag;
        fault_d[`SCF_FLT_TXMASK_BIT]  = txmask_flag;
        fault_d[`SCF_FLT_TIMEOUT_BIT] = timeout_flag;
        // [RULE7] reserved bits zero
        fault_d[`SCF_FLT_RSVD1_BIT]   = 1'b0;
        fault_d[`SCF_FLT_RSVD2_BIT]   = 1'b0;
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fault_q <= 8'h00;
        end else begin
            fault_q <= fault_d;
        end
    end

    // read path

    // data is captured at the read edge, before the clear lands
    always @* begin
        reg_rdata_d = reg_rdata_q;
        if (reg_rd) begin
            if (reg_addr == `SCF_ADDR_CONTROL) begin
                reg_rdata_d = `SCF_RDATA_RST;
                reg_rdata_d[`SCF_CTRL_MODE_HI:`SCF_CTRL_MODE_LO] = mode_q;
                reg_rdata_d[`SCF_CTRL_OUT_ON_BIT] = out_on_q;
            end else if (reg_addr == `SCF_ADDR_TRIG_CFG) begin
                reg_rdata_d = `SCF_RDATA_RST;
                reg_rdata_d[`SCF_TRIG_LEVEL_BIT] = trig_level_q;
                reg_rdata_d[`SCF_TRIG_EN_BIT]    = trig_en_q;
            end else if (reg_addr == `SCF_ADDR_FAULT) begin
                // [RULE9] return flags then clear
                reg_rdata_d = fault_d;
            end else begin
                reg_rdata_d = `SCF_RDATA_RST;
            end
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= `SCF_RDATA_RST;
        end else begin
            reg_rdata_q <= reg_rdata_d;
        end
    end

endmodule // scf_regs

`default_nettype wire

// ==== scf_regs_sva.sv ====
// assertions for the trigger config and fault flag bank
`timescale 1ns/1ps
`default_nettype none
module scf_regs_sva #(
    parameter CUR_W = 8
) (
    input wire logic             core_clk,
    input wire logic             nrst,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_rdata_q,
    input wire logic [7:0]       fault_q,
    input wire logic [CUR_W-1:0] led_current_in,
    input wire logic [CUR_W-1:0] eff_current_q,
    input wire logic             flash_active,
    input wire logic             flash_done,
    input wire logic             uvlo_evt,
    input wire logic             txmask_in,
    input wire logic             timeout_evt,
    input wire logic             trig_in,
    input wire logic             out_on_q,
    input wire logic             trig_level_q,
    input wire logic             trig_en_q,
    input wire logic             flash_trig_q,
    input wire logic [1:0]       mode_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire logic arm = trig_en_q && mode_q == 2'h3;
    // current follows the mode one edge earlier; skips the reset value
    a_assist_msb: assert property (nrst |=>
        eff_current_q == ($past(mode_q) == 2'h2 ? {1'b0,
        $past(led_current_in[CUR_W-2:0])} : $past(led_current_in)))
        else $error("effective current wrong");
    a_trig_level: assert property (arm && trig_level_q |=>
        flash_trig_q == $past(trig_in)) else $error("level trigger wrong");
    a_trig_edge: assert property (arm && !trig_level_q |=>
        flash_trig_q == ($past(trig_in) && !$past(trig_in, 2)))
        else $error("edge trigger wrong");
    a_trig_off: assert property (!arm |=> !flash_trig_q)
        else $error("trigger while disabled");
    a_cfg_read: assert property (reg_rd && reg_addr == 8'h07 |=>
        reg_rdata_q == {$past(trig_en_q), $past(trig_level_q), 6'h00})
        else $error("config read wrong");
    a_uvlo_set: assert property (uvlo_evt && flash_active |->
        ##2 fault_q[0]) else $error("undervoltage flag not set");
    a_txmask_set: assert property (txmask_in && flash_active |->
        ##2 fault_q[3]) else $error("mask flag not set");
    a_timeout_set: assert property (timeout_evt |-> ##2 fault_q[4])
        else $error("timeout flag not set");
    a_rsvd_zero: assert property ((fault_q & 8'he6) == 8'h00)
        else $error("reserved fault bit set");
    a_flash_clear: assert property (flash_done && mode_q == 2'h3 &&
        !(reg_wr && reg_addr == 8'h06) |=> mode_q == 2'h0 && !out_on_q)
        else $error("mode not cleared after flash");
    a_fault_read: assert property (reg_rd && reg_addr == 8'h08 |=>
        reg_rdata_q == fault_q) else $error("fault read wrong");
    a_fault_clear: assert property (reg_rd && reg_addr == 8'h08 &&
        !timeout_evt && !(flash_active && (uvlo_evt || txmask_in)) |->
        ##2 fault_q == 8'h00) else $error("fault not cleared by read");
    c_fault_seen: cover property (reg_rd && reg_addr == 8'h08 ##1
        reg_rdata_q != 8'h00);
    c_flash_end: cover property (flash_done && mode_q == 2'h3);
    c_edge_trig: cover property (arm && !trig_level_q && $rose(trig_in));
endmodule // scf_regs_sva
bind scf_regs scf_regs_sva #(.CUR_W(CUR_W)) scf_regs_sva_i (
    .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata_q(reg_rdata_q), .fault_q(fault_q),
    .led_current_in(led_current_in), .eff_current_q(eff_current_q),
    .flash_active(flash_active), .flash_done(flash_done),
    .uvlo_evt(uvlo_evt), .txmask_in(txmask_in),
    .timeout_evt(timeout_evt), .trig_in(trig_in), .out_on_q(out_on_q),
    .trig_level_q(trig_level_q), .trig_en_q(trig_en_q),
    .flash_trig_q(flash_trig_q), .mode_q(mode_q)
);
`default_nettype wire

// ==== scf_host.sv ====
// host model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module scf_host (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata_q,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd
);
    logic [7:0] rdata;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge core_clk);
        // released lines show inverted data, not a stale copy
        reg_addr <= ~a;
        reg_wdata <= ~d;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 rdata = reg_rdata_q;
    endtask
endmodule // scf_host
`default_nettype wire

// ==== strobe_config_and_fault_flags_test.sv ====
// self-checking bench for the trigger config and fault flag bank
`timescale 1ns/1ps
`default_nettype none
module strobe_config_and_fault_flags_test;
    logic        core_clk = 1'b0, nrst = 1'b0, reg_wr, reg_rd;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, fault_q, eff_current_q;
    logic [7:0]  led_current_in = 8'hff;
    logic        flash_active = 0, flash_done = 0, uvlo_evt = 0;
    logic        txmask_in = 0, timeout_evt = 0, trig_in = 0;
    logic        out_on_q, trig_level_q, trig_en_q, flash_trig_q;
    logic [1:0]  mode_q;
    int          err_count = 0, n_checks = 0;
    // address, write data, expected read back
    logic [23:0] rows [8] = '{24'h073f00, 24'h074040, 24'h078080,
        24'h07ffc0, 24'h08ff00, 24'h205a00, 24'h060602, 24'h060b0b};
    scf_regs #(.CUR_W(8)) scf_regs_i (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .led_current_in(led_current_in),
        .eff_current_q(eff_current_q), .flash_active(flash_active),
        .flash_done(flash_done), .uvlo_evt(uvlo_evt),
        .txmask_in(txmask_in), .timeout_evt(timeout_evt),
        .trig_in(trig_in), .mode_q(mode_q), .out_on_q(out_on_q),
        .trig_level_q(trig_level_q), .trig_en_q(trig_en_q),
        .flash_trig_q(flash_trig_q), .fault_q(fault_q)
    );
    scf_host scf_host_i (
        .core_clk(core_clk), .reg_rdata_q(reg_rdata_q),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd)
    );
    always #10 core_clk = ~core_clk;
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task conclude;
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // whole run is well under a thousand cycles
    initial begin
        #100000;
        err_count++;
        conclude();
    end
    initial begin
        tick(9);
        chk(trig_level_q, 1'b1);
        chk(trig_en_q, 1'b1);
        chk(fault_q, 8'h00);
        @(posedge core_clk);
        nrst <= 1'b1;
        scf_host_i.xfer(0, 8'h07, 0);
        chk(scf_host_i.rdata, 8'hc0);
        foreach (rows[i]) begin
            scf_host_i.xfer(1, rows[i][23:16], rows[i][15:8]);
            scf_host_i.xfer(0, rows[i][23:16], 0);
            chk(scf_host_i.rdata, rows[i][7:0]);
        end
        @(posedge core_clk);
        {flash_active, uvlo_evt, txmask_in, timeout_evt} <= 4'hf;
        @(posedge core_clk);
        {flash_active, uvlo_evt, txmask_in, timeout_evt} <= 4'h0;
        scf_host_i.xfer(0, 8'h08, 0);
        chk(scf_host_i.rdata, 8'h19);
        scf_host_i.xfer(0, 8'h08, 0);
        chk(scf_host_i.rdata, 8'h00);
        @(posedge core_clk);
        {uvlo_evt, txmask_in} <= 2'h3;
        @(posedge core_clk);
        {uvlo_evt, txmask_in, timeout_evt} <= 3'h1;
        scf_host_i.xfer(0, 8'h08, 0);
        chk(scf_host_i.rdata, 8'h10);
        scf_host_i.xfer(0, 8'h08, 0);
        chk(scf_host_i.rdata, 8'h10);
        @(posedge core_clk);
        timeout_evt <= 1'b0;
        scf_host_i.xfer(0, 8'h08, 0);
        chk(scf_host_i.rdata, 8'h10);
        scf_host_i.xfer(0, 8'h08, 0);
        chk(scf_host_i.rdata, 8'h00);
        @(posedge core_clk);
        trig_in <= 1'b1;
        tick(2);
        chk(flash_trig_q, 1'b1);
        scf_host_i.xfer(1, 8'h07, 8'h40);
        tick(2);
        chk(flash_trig_q, 1'b0);
        scf_host_i.xfer(1, 8'h07, 8'h80);
        tick(3);
        chk(flash_trig_q, 1'b0);
        @(posedge core_clk);
        trig_in <= 1'b0;
        @(posedge core_clk);
        trig_in <= 1'b1;
        tick(1);
        chk(flash_trig_q, 1'b1);
        chk({out_on_q, mode_q}, 8'h07);
        @(posedge core_clk);
        flash_done <= 1'b1;
        @(posedge core_clk);
        flash_done <= 1'b0;
        #1 chk({out_on_q, mode_q}, 8'h00);
        scf_host_i.xfer(1, 8'h06, 8'h02);
        tick(1);
        chk(eff_current_q, 8'h7f);
        scf_host_i.xfer(1, 8'h06, 8'h03);
        tick(1);
        chk(eff_current_q, 8'hff);
        conclude();
    end
endmodule // strobe_config_and_fault_flags_test
`default_nettype wire
